// ---- rtl/mtdls_pkg.sv ----
// Shared constants and types for the MAC transmit-defer and length statistics counters
package mtdls_pkg;

  localparam int NUM_CNT = 4;

  // Counter slots, also the bit positions in the per-counter mask
  localparam int IDX_GOOD_TX    = 0;
  localparam int IDX_DEFER_TX   = 1;
  localparam int IDX_EXCESS_DEF = 2;
  localparam int IDX_OVERSIZE   = 3;

  // Byte offsets inside the host I/O or memory window
  localparam logic [7:0] GOOD_TX_OFFSET    = 8'hDC;
  localparam logic [7:0] DEFER_TX_OFFSET   = 8'hE4;
  localparam logic [7:0] EXCESS_DEF_OFFSET = 8'hE8;
  localparam logic [7:0] OVERSIZE_OFFSET   = 8'hEC;

  localparam int WIDE_BITS   = 32;
  localparam int NARROW_BITS = 16;

  localparam logic [31:0] WIDE_THRESH   = 32'hC0000000;
  localparam logic [31:0] NARROW_THRESH = 32'h0000C000;
  localparam logic [31:0] COUNT_RESET   = 32'h00000000;

  // Lanes that make a whole double word or a whole low word
  localparam logic [3:0] DWORD_LANES = 4'hF;
  localparam logic [3:0] WORD_LANES  = 4'h3;

  localparam int          CNT_WIDTH  [NUM_CNT] = '{WIDE_BITS, WIDE_BITS, NARROW_BITS, NARROW_BITS};
  localparam logic [7:0]  CNT_OFFSET [NUM_CNT] = '{GOOD_TX_OFFSET, DEFER_TX_OFFSET,
                                                   EXCESS_DEF_OFFSET, OVERSIZE_OFFSET};
  localparam logic [31:0] CNT_THRESH [NUM_CNT] = '{WIDE_THRESH, WIDE_THRESH, NARROW_THRESH, NARROW_THRESH};

  typedef logic [31:0] mtdls_word_t;

  typedef struct packed {
    logic done;
    logic ok;
    logic deferred;
    logic collided;
  } mtdls_tx_report_s;

  typedef struct packed {
    logic        done;
    logic [15:0] length;
  } mtdls_rx_report_s;

  typedef struct packed {
    logic        sel;
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [3:0]  byteEn;
    mtdls_word_t wrData;
  } mtdls_reg_req_s;

  typedef enum {
    DEFER_FREE,
    DEFER_COUNTED
  } mtdls_defer_state_e;

endpackage

// ---- rtl/mtdls_counter.sv ----
// One wrapping statistics counter with software write and threshold detection
`timescale 1ns/1ps
module mtdls_counter #(
  parameter int          WIDTH  = 32,
  parameter logic [31:0] THRESH = 32'hC0000000
) (
  input  wire logic                   mclk,
  input  wire logic                   srst,
  input  wire logic                   mclkEn,
  input  wire logic                   incEn,
  input  wire logic                   wrEn,
  input  wire mtdls_pkg::mtdls_word_t wrData,
  output mtdls_pkg::mtdls_word_t      countVal,
  output logic                        thresholdHit
);
  import mtdls_pkg::*;

  localparam logic [31:0] MAX_MASK = 32'hFFFFFFFF >> (32 - WIDTH);

  generate
    if (WIDTH < 1 || WIDTH > 32 || (THRESH & ~MAX_MASK) != 32'h00000000) begin : g_bad
      $error("mtdls_counter: width or threshold out of range");
    end
  endgenerate

  mtdls_word_t count_q;
  mtdls_word_t count_d;
  logic        hit_q;

  // Masking the sum gives the wrap to zero after the all-ones value
  assign count_d = (count_q + 32'h00000001) & MAX_MASK;

  always_ff @(posedge mclk) begin
    if (srst) begin
      count_q <= COUNT_RESET;
    end else if (mclkEn) begin
      // A software write in the same cycle as an event wins; the event is lost
      if (wrEn) begin
        count_q <= wrData & MAX_MASK;
      end else if (incEn) begin
        count_q <= count_d;
      end
    end
  end

  // Only an increment landing on the threshold fires, not a write of it
  always_ff @(posedge mclk) begin
    if (srst) begin
      hit_q <= 1'b0;
    end else if (mclkEn) begin
      hit_q <= incEn && !wrEn && (count_d == THRESH);
    end
  end

  assign countVal     = count_q;
  assign thresholdHit = hit_q;
endmodule

// ---- rtl/mtdls_sticky_flag.sv ----
// Sticky event flag where a new event beats an acknowledge in the same cycle
`timescale 1ns/1ps
module mtdls_sticky_flag (
  input  wire logic mclk,
  input  wire logic srst,
  input  wire logic mclkEn,
  input  wire logic setEv,
  input  wire logic clrEv,
  output logic      flag
);
  logic flag_q;

  always_ff @(posedge mclk) begin
    if (srst) begin
      flag_q <= 1'b0;
    end else if (mclkEn) begin
      if (setEv) begin
        flag_q <= 1'b1;
      end else if (clrEv) begin
        flag_q <= 1'b0;
      end
    end
  end

  assign flag = flag_q;
endmodule

// ---- rtl/mtdls_stats_top.sv ----
// Transmit-defer, good-transmit and oversize-receive statistics counters with register access
//
// Overview of operation
// - Count frames whose first attempt deferred.
// - Deferred counter never counts frames that collided.
// - Deferred counter wraps to zero after all-ones.
// - Deferred counter reaching threshold raises event.
// - Deferred counter needs global on, mask clear.
// - Count frames exceeding the defer limit.
// - Excess deferral counted once per frame.
// - Excess counter wraps; threshold raises event.
// - Excess counter needs global on, mask clear.
// - Count successfully transmitted frames.
// - Good counter wraps; threshold raises event.
// - Good counter needs global on, mask clear.
// - Count received frames longer than maximum.
// - Oversize counter wraps; threshold raises event.
// - Oversize counter needs global on, mask clear.
// - Wide counters reset zero, dword read/write.
`timescale 1ns/1ps
module mtdls_stats_top (
  input  wire logic                        mclk,
  input  wire logic                        srst,
  input  wire logic                        mclkEn,
  input  wire mtdls_pkg::mtdls_reg_req_s   regReq,
  output mtdls_pkg::mtdls_word_t           regRdData,
  output logic                             regRdAck,
  output logic                             regAccessErr,
  input  wire logic                        countersGlobalOn,
  input  wire logic [3:0]                  counterMask,
  input  wire logic [15:0]                 maxFrameLength,
  input  wire mtdls_pkg::mtdls_tx_report_s txReport,
  input  wire logic                        txExcessDefer,
  input  wire mtdls_pkg::mtdls_rx_report_s rxReport,
  input  wire logic                        thresholdAck,
  output logic                             counterThresholdEvent
);
  import mtdls_pkg::*;

  logic [NUM_CNT-1:0] countEnable;
  logic [NUM_CNT-1:0] rawEvent;
  logic [NUM_CNT-1:0] incEn;
  logic [NUM_CNT-1:0] addrHit;
  logic [NUM_CNT-1:0] lanesOk;
  logic [NUM_CNT-1:0] wrEn;
  logic [NUM_CNT-1:0] hitVec;
  mtdls_word_t        cntVal [NUM_CNT];

  mtdls_defer_state_e deferState_q;
  mtdls_defer_state_e deferState_d;

  mtdls_word_t rdData_q;
  mtdls_word_t rdData_d;
  logic        rdAck_q;
  logic        accessErr_q;
  logic        accessReq;
  logic        badAccess;

  // Event decode from the MAC datapath, all strobes on mclk
  assign rawEvent[IDX_GOOD_TX]  = txReport.done && txReport.ok;
  assign rawEvent[IDX_DEFER_TX] = txReport.done && txReport.deferred
                                  && !txReport.collided;
  assign rawEvent[IDX_EXCESS_DEF] = txExcessDefer
                                    && (deferState_q == DEFER_FREE);
  assign rawEvent[IDX_OVERSIZE] = rxReport.done
                                  && (rxReport.length > maxFrameLength);

  // One excessive-deferral count per frame; the frame's completion re-arms it
  always_comb begin
    deferState_d = deferState_q;
    case (deferState_q)
      DEFER_FREE: begin
        if (txExcessDefer && !txReport.done) begin
          deferState_d = DEFER_COUNTED;
        end
      end
      DEFER_COUNTED: begin
        if (txReport.done) begin
          deferState_d = DEFER_FREE;
        end
      end
      default: begin
        deferState_d = DEFER_FREE;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      deferState_q <= DEFER_FREE;
    end else if (mclkEn) begin
      deferState_q <= deferState_d;
    end
  end

  // Register access decode
  assign accessReq = regReq.sel && (regReq.wr || regReq.rd);

  generate
    for (genvar i = 0; i < NUM_CNT; i++) begin : g_cnt
      assign countEnable[i] = countersGlobalOn && !counterMask[i];
      assign incEn[i]       = rawEvent[i] && countEnable[i];
      assign addrHit[i]     = (regReq.addr == CNT_OFFSET[i]);
      // Partial accesses would tear a live counter, so they are refused
      assign lanesOk[i]     = (CNT_WIDTH[i] == WIDE_BITS) ? (regReq.byteEn == DWORD_LANES)
                                                          : (regReq.byteEn == WORD_LANES);
      assign wrEn[i]        = regReq.sel && regReq.wr && addrHit[i] && lanesOk[i];

      mtdls_counter #(
        .WIDTH  (CNT_WIDTH[i]),
        .THRESH (CNT_THRESH[i])
      ) u_counter (
        .mclk         (mclk),
        .srst         (srst),
        .mclkEn       (mclkEn),
        .incEn        (incEn[i]),
        .wrEn         (wrEn[i]),
        .wrData       (regReq.wrData),
        .countVal     (cntVal[i]),
        .thresholdHit (hitVec[i])
      );
    end
  endgenerate

  assign badAccess = accessReq && |(addrHit & ~lanesOk);

  always_comb begin
    rdData_d = COUNT_RESET;
    for (int i = 0; i < NUM_CNT; i++) begin
      if (addrHit[i] && lanesOk[i]) begin
        rdData_d = cntVal[i];
      end
    end
  end

  // Read data and acknowledge one cycle after the request; unmapped reads give zero
  always_ff @(posedge mclk) begin
    if (srst) begin
      rdData_q <= COUNT_RESET;
      rdAck_q  <= 1'b0;
    end else if (mclkEn) begin
      rdAck_q <= regReq.sel && regReq.rd;
      if (regReq.sel && regReq.rd) begin
        rdData_q <= rdData_d;
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      accessErr_q <= 1'b0;
    end else if (mclkEn) begin
      accessErr_q <= badAccess;
    end
  end

  mtdls_sticky_flag u_threshold_flag (
    .mclk   (mclk),
    .srst   (srst),
    .mclkEn (mclkEn),
    .setEv  (|hitVec),
    .clrEv  (thresholdAck),
    .flag   (counterThresholdEvent)
  );

  assign regRdData    = rdData_q;
  assign regRdAck     = rdAck_q;
  assign regAccessErr = accessErr_q;
endmodule

// ---- test/mtdls_stats_checker.sv ----
// Port-level assertions for the statistics counter block
`timescale 1ns/1ps
module mtdls_stats_checker (
  input wire logic                        mclk,
  input wire logic                        srst,
  input wire logic                        mclkEn,
  input wire mtdls_pkg::mtdls_reg_req_s   regReq,
  input wire mtdls_pkg::mtdls_word_t      regRdData,
  input wire logic                        regRdAck,
  input wire logic                        regAccessErr,
  input wire mtdls_pkg::mtdls_tx_report_s txReport,
  input wire logic                        txExcessDefer,
  input wire mtdls_pkg::mtdls_rx_report_s rxReport,
  input wire logic                        thresholdAck,
  input wire logic                        counterThresholdEvent
);
  import mtdls_pkg::*;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);
  wire logic rdReq = mclkEn && regReq.sel && regReq.rd;
  rd_ack_a: assert property (rdReq |=> regRdAck) else $error("read not acknowledged");
  no_ack_a: assert property (mclkEn && !rdReq |=> !regRdAck) else $error("stray read ack");
  lane_err_a: assert property (mclkEn && regReq.sel && regReq.wr && regReq.addr == GOOD_TX_OFFSET
    && regReq.byteEn != DWORD_LANES |=> regAccessErr) else $error("partial write not flagged");
  no_err_a: assert property (mclkEn && !regReq.sel |=> !regAccessErr) else $error("stray error");
  data_hold_a: assert property (!rdReq |=> $stable(regRdData)) else $error("read data moved");
  unmapped_zero_a: assert property (rdReq && regReq.addr == 8'h00 |=> regRdData == 32'h0)
    else $error("unmapped read not zero");
  event_hold_a: assert property (counterThresholdEvent && !thresholdAck |=> counterThresholdEvent)
    else $error("event dropped");
  // Without a count event two cycles back the flag cannot rise
  event_cause_a: assert property (mclkEn && !counterThresholdEvent && !txReport.done && !rxReport.done
    && !txExcessDefer ##1 mclkEn && !counterThresholdEvent |=> !counterThresholdEvent)
    else $error("event without cause");
endmodule
bind mtdls_stats_top mtdls_stats_checker chkInst (.mclk, .srst, .mclkEn, .regReq, .regRdData, .regRdAck,
  .regAccessErr, .txReport, .txExcessDefer, .rxReport, .thresholdAck, .counterThresholdEvent);

// ---- test/mtdls_stats_top_bench.sv ----
// Self-checking bench for the statistics counter block
`timescale 1ns/1ps
module mtdls_stats_top_bench;
  import mtdls_pkg::*;
  logic             mclk = 0, srst = 1, mclkEn = 1, gOn = 0, xDef = 0, ack = 0, rdAck, accErr, evt;
  logic [3:0]       mask = 4'h0;
  logic [15:0]      maxLen = 16'h0064;
  mtdls_reg_req_s   req = '0;
  mtdls_tx_report_s tx = '0;
  mtdls_rx_report_s rx = '0;
  mtdls_word_t      rdData;
  mtdls_word_t      m [NUM_CNT] = '{default: 32'h0};
  int               errCount = 0, samplesChecked = 0;
  mtdls_stats_top DUT (.mclk, .srst, .mclkEn, .regReq(req), .regRdData(rdData), .regRdAck(rdAck),
    .regAccessErr(accErr), .countersGlobalOn(gOn), .counterMask(mask), .maxFrameLength(maxLen),
    .txReport(tx), .txExcessDefer(xDef), .rxReport(rx), .thresholdAck(ack), .counterThresholdEvent(evt));
  initial forever #4 mclk = ~mclk;
  function automatic logic [31:0] mk(int j);
    return CNT_WIDTH[j] == WIDE_BITS ? 32'hFFFFFFFF : 32'h0000FFFF;
  endfunction
  function automatic logic [3:0] ln(int j);
    return CNT_WIDTH[j] == WIDE_BITS ? DWORD_LANES : WORD_LANES;
  endfunction
  task automatic chk(string nm, logic [31:0] got, logic [31:0] exp);
    samplesChecked++;
    if (got !== exp) begin
      errCount++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic acc(logic w, logic [7:0] a, logic [3:0] be, logic [31:0] d);
    @(posedge mclk);
    req <= {1'h1, w, !w, a, be, d};
    @(posedge mclk);
    req <= '0;
    #1;
  endtask
  task automatic wr1(int j, logic [31:0] v);
    acc(1, CNT_OFFSET[j], ln(j), v);
    m[j] = v & mk(j);
  endtask
  task automatic chkAll();
    for (int j = 0; j < NUM_CNT; j++) begin
      acc(0, CNT_OFFSET[j], ln(j), 32'h0);
      chk("ack", rdAck, 1);
      chk("count", rdData, m[j]);
    end
  endtask
  // All four count causes in one cycle; excess with frame end leaves the window open
  task automatic fire();
    @(posedge mclk);
    tx <= 4'hE;
    xDef <= 1;
    rx <= {1'h1, maxLen + 16'h0001};
    @(posedge mclk);
    tx <= '0;
    xDef <= 0;
    rx <= '0;
    for (int j = 0; j < NUM_CNT; j++)
      if (mclkEn && gOn && !mask[j]) m[j] = (m[j] + 1) & mk(j);
    #1;
  endtask
  task automatic tEnable();
    gOn <= 1;
    for (int i = 0; i < 5; i++) begin
      mask <= (i < 4) ? 4'h1 << i : 4'h0;
      fire();
      chkAll();
    end
    gOn <= 0;
    fire();
    chkAll();
    gOn <= 1;
  endtask
  task automatic tFilter();
    @(posedge mclk);
    tx <= 4'hB;
    rx <= {1'h1, maxLen};
    @(posedge mclk);
    tx <= '0;
    rx <= '0;
    xDef <= 1;
    repeat (2) @(posedge mclk);
    xDef <= 0;
    tx <= 4'h8;
    @(posedge mclk);
    tx <= '0;
    m[IDX_EXCESS_DEF]++;
    chkAll();
  endtask
  task automatic tWrap();
    for (int j = 0; j < NUM_CNT; j++) wr1(j, 32'hFFFFFFFF);
    chkAll();
    fire();
    repeat (3) @(posedge mclk);
    #1 chk("event", evt, 0);
    chkAll();
  endtask
  task automatic tThresh();
    for (int j = 0; j < NUM_CNT; j++) begin
      mask <= ~(4'h1 << j);
      wr1(j, CNT_THRESH[j] - 1);
      fire();
      repeat (2) @(posedge mclk);
      #1 chk("event", evt, 1);
      ack <= 1;
      @(posedge mclk);
      ack <= 0;
      #1 chk("acked", evt, 0);
    end
    mask <= 4'h0;
    chkAll();
  endtask
  task automatic tRefuse();
    acc(1, GOOD_TX_OFFSET, WORD_LANES, 32'h12345678);
    chk("lane error", accErr, 1);
    acc(0, GOOD_TX_OFFSET, 4'h1, 32'h0);
    chk("part read", rdData, 32'h0);
    chk("read lane error", accErr, 1);
    acc(0, 8'h00, DWORD_LANES, 32'h0);
    chk("unmapped", rdData, 32'h0);
    chkAll();
  endtask
  // Clock enable low: events, a write and a read must all leave the state untouched
  task automatic tFreeze();
    @(posedge mclk);
    mclkEn <= 0;
    fire();
    acc(1, GOOD_TX_OFFSET, DWORD_LANES, 32'h0000005A);
    acc(0, GOOD_TX_OFFSET, DWORD_LANES, 32'h0);
    chk("frozen ack", rdAck, 0);
    chk("frozen data", rdData, m[IDX_OVERSIZE]);
    @(posedge mclk);
    mclkEn <= 1;
    chkAll();
  endtask
  // A hit beats an acknowledge in the same cycle; a write beats a count
  task automatic tSetWins();
    mask <= 4'hE;
    wr1(IDX_GOOD_TX, WIDE_THRESH - 32'h00000001);
    fire();
    ack <= 1;
    @(posedge mclk);
    ack <= 0;
    #1 chk("set wins", evt, 1);
    ack <= 1;
    @(posedge mclk);
    ack <= 0;
    #1 chk("acked", evt, 0);
    @(posedge mclk);
    mask <= 4'h0;
    req <= {1'h1, 1'h1, 1'h0, GOOD_TX_OFFSET, DWORD_LANES, 32'h00000007};
    tx <= 4'hC;
    @(posedge mclk);
    req <= '0;
    tx <= '0;
    m[IDX_GOOD_TX] = 32'h00000007;
    chkAll();
  endtask
  task automatic results();
    $display("Checked %0d, mismatches %0d", samplesChecked, errCount);
    if (errCount == 0 && samplesChecked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Watchdog bound well above the full sequence length
  initial begin
    repeat (20000) @(posedge mclk);
    errCount++;
    results();
  end
  initial begin
    repeat (16) @(posedge mclk);
    srst <= 0;
    @(posedge mclk);
    #1 chkAll();
    tEnable();
    tFilter();
    tWrap();
    tThresh();
    tRefuse();
    tFreeze();
    tSetWins();
    results();
  end
endmodule
